/* src/rvm_params.svh */
// Constants for the relocatable vector map
`ifndef RVM_PARAMS_SVH
`define RVM_PARAMS_SVH
// Table geometry
`define RVM_TABLE_BYTES 256
`define RVM_ENTRY_BYTES 4
`define RVM_NUM_W 6
`define RVM_NUM_CNT 64
// Vector numbers of the hardware sources
`define RVM_NUM_BREAK 6'h00
`define RVM_NUM_DMA0 6'h08
`define RVM_NUM_TMRA0 6'h0C
`define RVM_NUM_UART_TX0 6'h11
`define RVM_NUM_UART_TX2 6'h21
`define RVM_NUM_TMRB0 6'h15
`define RVM_NUM_TMRB5 6'h20
`define RVM_NUM_EXT0 6'h1F
`define RVM_NUM_BUS2 6'h27
`define RVM_NUM_BUS30 6'h28
`define RVM_NUM_BUS41 6'h29
`define RVM_NUM_ADC0 6'h2A
`define RVM_NUM_KEY 6'h2B
`define RVM_NUM_AIO0 6'h2C
`define RVM_NUM_AIO1 6'h2D
`define RVM_NUM_AIO2 6'h2E
`define RVM_NUM_CAN5 6'h31
`define RVM_NUM_AIO8 6'h34
`define RVM_NUM_AIO9 6'h35
`define RVM_NUM_AIO10 6'h36
`define RVM_NUM_CAN2 6'h39
// Numbers that hardware may raise (8-49, 52-54, 57)
`define RVM_HW_MASK 64'h0273FFFF_FFFFFF00
// Register byte offsets
`define RVM_AXI_AW 8
`define RVM_OFS_BASE 8'h00
`define RVM_OFS_SEL 8'h04
`define RVM_OFS_PEND_LO 8'h08
`define RVM_OFS_PEND_HI 8'h0C
`define RVM_OFS_PRIO0 8'h10
`define RVM_OFS_STATUS 8'h30
`define RVM_OFS_FETCH 8'h34
`define RVM_PRIO_WORDS 8
// Field positions
`define RVM_SEL_03_BIT 6
`define RVM_SEL_14_BIT 7
`define RVM_ST_NUM_LSB 0
`define RVM_ST_LVL_LSB 8
`define RVM_ST_REQ_BIT 16
`define RVM_ST_VNUM_LSB 24
// Reset values and responses
`define RVM_BASE_RST 32'h0000_0000
`define RVM_SEL_RST 32'h0000_0000
`define RVM_RESP_OKAY 2'h0
`define RVM_RESP_SLVERR 2'h2
`endif

/* src/rvm_pkg.sv */
// Types shared by the relocatable vector map
`default_nettype none
package rvm_pkg;
   typedef logic [5:0] rvm_num_t;
   typedef logic [2:0] rvm_lvl_t;
   typedef enum {RVM_SEQ_IDLE, RVM_SEQ_ISSUE} rvm_seq_t;
endpackage
`default_nettype wire

/* src/rvm_source_map.sv */
// Routes every peripheral request line but the deselected bus line of each shared pair onto its vector number
`default_nettype none
`include "rvm_params.svh"
module rvm_source_map (
   // Peripheral requests
   input wire logic [3:0] dma_done,
   input wire logic [4:0] timer_group_a_ch,
   input wire logic [4:0] uart_tx,
   input wire logic [4:0] uart_rx,
   input wire logic [5:0] timer_group_b_ch,
   input wire logic [5:0] ext_pin_irq,
   input wire logic [4:0] uart_bus_cond,
   input wire logic adc_unit0,
   input wire logic key_input,
   input wire logic [4:0] aio_irq_lo,
   input wire logic [2:0] aio_irq_hi,
   input wire logic [5:0] can_irq,
   // Shared vector selection
   input wire logic uart0_uart3_vector_sel,
   input wire logic uart1_uart4_vector_sel,
   // One request bit per vector number
   output logic [63:0] event_vec
);
   // Reserved numbers are never written, so they stay zero
   always_comb begin
      event_vec = 64'h0;
      for (int i = 0; i < 4; i++) begin
         event_vec[`RVM_NUM_DMA0 + i] = dma_done[i];
      end
      for (int i = 0; i < 5; i++) begin
         event_vec[`RVM_NUM_TMRA0 + i] = timer_group_a_ch[i];
         event_vec[`RVM_NUM_TMRB0 + i] = timer_group_b_ch[i];
      end
      event_vec[`RVM_NUM_TMRB5] = timer_group_b_ch[5];
      for (int i = 0; i < 2; i++) begin
         event_vec[`RVM_NUM_UART_TX0 + 2*i] = uart_tx[i];
         event_vec[`RVM_NUM_UART_TX0 + 2*i + 1] = uart_rx[i];
      end
      for (int i = 2; i < 5; i++) begin
         event_vec[`RVM_NUM_UART_TX2 + 2*(i-2)] = uart_tx[i];
         event_vec[`RVM_NUM_UART_TX2 + 2*(i-2) + 1] = uart_rx[i];
      end
      // Pin 0 sits at the top of the group
      for (int i = 0; i < 6; i++) begin
         event_vec[`RVM_NUM_EXT0 - i] = ext_pin_irq[i];
      end
      // Only the selected channel of a pair reaches the shared slot
      event_vec[`RVM_NUM_BUS2] = uart_bus_cond[2];
      event_vec[`RVM_NUM_BUS30] = uart0_uart3_vector_sel ?
         uart_bus_cond[0] : uart_bus_cond[3];
      event_vec[`RVM_NUM_BUS41] = uart1_uart4_vector_sel ?
         uart_bus_cond[1] : uart_bus_cond[4];
      event_vec[`RVM_NUM_ADC0] = adc_unit0;
      event_vec[`RVM_NUM_KEY] = key_input;
      // Shared numbers: either source raises the one vector
      event_vec[`RVM_NUM_AIO0] = aio_irq_lo[0] | can_irq[3];
      event_vec[`RVM_NUM_AIO1] = aio_irq_lo[1] | can_irq[4];
      for (int i = 2; i < 5; i++) begin
         event_vec[`RVM_NUM_AIO2 + i - 2] = aio_irq_lo[i];
      end
      event_vec[`RVM_NUM_CAN5] = can_irq[5];
      event_vec[`RVM_NUM_AIO8] = aio_irq_hi[0];
      event_vec[`RVM_NUM_AIO9] = aio_irq_hi[1] | can_irq[0];
      event_vec[`RVM_NUM_AIO10] = aio_irq_hi[2] | can_irq[1];
      event_vec[`RVM_NUM_CAN2] = can_irq[2];
   end
endmodule // rvm_source_map
`default_nettype wire

/* src/rvm_vector_map.sv */
// Relocatable vector map: flags, arbitration, vector fetch, AXI registers
`default_nettype none
`include "rvm_params.svh"
module rvm_vector_map
   import rvm_pkg::*;
(
   // Clock, reset and clock enable
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // AXI4-Lite write address and data
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // CPU flags, same clock
   input wire logic cpu_int_enable,
   input wire logic [2:0] processor_priority_level,
   // CPU sequencer requests
   input wire logic ack_req,
   input wire logic trap_req,
   input wire logic [5:0] trap_num,
   // Pending request offered to the CPU
   output logic irq_req,
   output logic [5:0] irq_num,
   output logic [2:0] irq_level,
   // Vector fetch answer
   output logic vec_valid,
   output logic [31:0] vec_addr,
   output logic [5:0] vec_num,
   // Peripheral requests, same clock
   input wire logic [3:0] dma_done,
   input wire logic [4:0] timer_group_a_ch,
   input wire logic [4:0] uart_tx,
   input wire logic [4:0] uart_rx,
   input wire logic [5:0] timer_group_b_ch,
   input wire logic [4:0] uart_bus_cond,
   input wire logic adc_unit0,
   input wire logic key_input,
   input wire logic [4:0] aio_irq_lo,
   input wire logic [2:0] aio_irq_hi,
   input wire logic [5:0] can_irq,
   // External interrupt pins, asynchronous, active high
   input wire logic [5:0] ext_pin_irq
);

   // Byte-lane merge used by the base and source select registers
   function automatic logic [31:0] rvm_merge(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] strb);
      logic [31:0] m;
      m = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            m[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return m;
   endfunction

   // Entry address; the base is kept as is, odd values included
   function automatic logic [31:0] rvm_slot(input logic [31:0] base,
      input rvm_num_t num);
      return base + {24'h0, num, 2'h0};
   endfunction

   // Register word decode, ignoring the byte offset
   function automatic logic [7:0] rvm_word(input logic [7:0] a);
      return {a[7:2], 2'h0};
   endfunction

   logic [5:0] ext_meta_reg;
   logic [5:0] ext_sync_reg;
   logic [5:0] ext_prev_reg;
   logic [5:0] ext_rise;
   logic [63:0] event_vec;
   logic [31:0] vector_base_reg;
   logic [31:0] source_select_reg;
   logic [63:0] pend_reg;
   logic [63:0] pend_next;
   logic [63:0] sw_clr;
   logic [63:0] ack_clr;
   rvm_lvl_t prio_reg [0:63];
   logic aw_full_reg;
   logic w_full_reg;
   logic [7:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic wr_go;
   logic wr_hit;
   logic [31:0] rd_data;
   logic rd_hit;
   logic best_found;
   rvm_num_t best_num;
   rvm_lvl_t best_lvl;
   logic ack_take;
   logic trap_take;
   logic [31:0] fetch_reg;
   rvm_seq_t seq_reg;
   rvm_seq_t seq_next;

   // Pins come from outside the clock domain: two flops, then an edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ext_meta_reg <= 6'h00;
         ext_sync_reg <= 6'h00;
         ext_prev_reg <= 6'h00;
      end else if (ce) begin
         ext_meta_reg <= ext_pin_irq;
         ext_sync_reg <= ext_meta_reg;
         ext_prev_reg <= ext_sync_reg;
      end
   end
   assign ext_rise = ext_sync_reg & ~ext_prev_reg;

   // Source routing onto vector numbers
   rvm_source_map u_map (
      .dma_done(dma_done),
      .timer_group_a_ch(timer_group_a_ch),
      .uart_tx(uart_tx),
      .uart_rx(uart_rx),
      .timer_group_b_ch(timer_group_b_ch),
      .ext_pin_irq(ext_rise),
      .uart_bus_cond(uart_bus_cond),
      .adc_unit0(adc_unit0),
      .key_input(key_input),
      .aio_irq_lo(aio_irq_lo),
      .aio_irq_hi(aio_irq_hi),
      .can_irq(can_irq),
      .uart0_uart3_vector_sel(source_select_reg[`RVM_SEL_03_BIT]),
      .uart1_uart4_vector_sel(source_select_reg[`RVM_SEL_14_BIT]),
      .event_vec(event_vec)
   );

   // Write address and data are caught in either order
   assign wr_go = aw_full_reg && w_full_reg && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         s_axi_awready <= 1'b1;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end else if (wr_go) begin
            aw_full_reg <= 1'b0;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
         end
      end
   end

   // Write data holding; ready returns only after the response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_full_reg <= 1'b0;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
         s_axi_wready <= 1'b1;
      end else if (ce) begin
         if (s_axi_wvalid && s_axi_wready) begin
            w_full_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end else if (wr_go) begin
            w_full_reg <= 1'b0;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Write decode; status and fetch words are read-only
   always_comb begin
      wr_hit = 1'b0;
      case (rvm_word(aw_addr_reg))
         `RVM_OFS_BASE, `RVM_OFS_SEL: wr_hit = 1'b1;
         `RVM_OFS_PEND_LO, `RVM_OFS_PEND_HI: wr_hit = 1'b1;
         default: begin
            wr_hit = (rvm_word(aw_addr_reg) >= `RVM_OFS_PRIO0) &&
               (rvm_word(aw_addr_reg) < `RVM_OFS_STATUS);
         end
      endcase
   end

   // Write response: SLVERR for unmapped or read-only words
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RVM_RESP_OKAY;
      end else if (ce) begin
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `RVM_RESP_OKAY : `RVM_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Vector base register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         vector_base_reg <= `RVM_BASE_RST;
      end else if (ce && wr_go &&
         rvm_word(aw_addr_reg) == `RVM_OFS_BASE) begin
         vector_base_reg <= rvm_merge(vector_base_reg, w_data_reg,
            w_strb_reg);
      end
   end

   // Source select register; only the two select bits are kept
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         source_select_reg <= `RVM_SEL_RST;
      end else if (ce && wr_go &&
         rvm_word(aw_addr_reg) == `RVM_OFS_SEL) begin
         source_select_reg <= rvm_merge(source_select_reg, w_data_reg,
            w_strb_reg) & 32'h0000_00C0;
      end
   end

   // Priority fields, eight per word, one nibble each
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int n = 0; n < `RVM_NUM_CNT; n++) begin
            prio_reg[n] <= 3'h0;
         end
      end else if (ce && wr_go) begin
         for (int k = 0; k < `RVM_PRIO_WORDS; k++) begin
            if (rvm_word(aw_addr_reg) == `RVM_OFS_PRIO0 + 8'(4*k)) begin
               for (int j = 0; j < 8; j++) begin
                  if (w_strb_reg[j/2]) begin
                     prio_reg[8*k+j] <= w_data_reg[4*j +: 3];
                  end
               end
            end
         end
      end
   end

   // Software may only clear pending flags, by writing zero
   always_comb begin
      sw_clr = 64'h0;
      if (wr_go && rvm_word(aw_addr_reg) == `RVM_OFS_PEND_LO) begin
         for (int b = 0; b < 32; b++) begin
            sw_clr[b] = w_strb_reg[b/8] && !w_data_reg[b];
         end
      end
      if (wr_go && rvm_word(aw_addr_reg) == `RVM_OFS_PEND_HI) begin
         for (int b = 0; b < 32; b++) begin
            sw_clr[32+b] = w_strb_reg[b/8] && !w_data_reg[b];
         end
      end
   end

   // Acknowledged vector drops its flag
   always_comb begin
      ack_clr = 64'h0;
      ack_clr[irq_num] = ack_take;
   end

   // Pending flags: a new request outranks a clear in the same cycle
   assign pend_next = ((pend_reg & ~sw_clr & ~ack_clr) | event_vec) &
      `RVM_HW_MASK;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pend_reg <= 64'h0;
      end else if (ce) begin
         pend_reg <= pend_next;
      end
   end

   // Pick the highest level above the CPU level; lowest number wins a tie
   always_comb begin
      best_found = 1'b0;
      best_num = 6'h00;
      best_lvl = 3'h0;
      for (int n = 0; n < `RVM_NUM_CNT; n++) begin
         if (cpu_int_enable && pend_reg[n] &&
            prio_reg[n] > processor_priority_level &&
            (!best_found || prio_reg[n] > best_lvl)) begin
            best_found = 1'b1;
            best_num = 6'(n);
            best_lvl = prio_reg[n];
         end
      end
   end

   // Acknowledge only an offered request; a trap needs an idle sequencer
   assign ack_take = (seq_reg == RVM_SEQ_IDLE) && ack_req && irq_req;
   assign trap_take = (seq_reg == RVM_SEQ_IDLE) && trap_req && !ack_take;

   // Offered request; withdrawn at acknowledge so the flag can settle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_req <= 1'b0;
         irq_num <= 6'h00;
         irq_level <= 3'h0;
      end else if (ce) begin
         irq_req <= best_found && !ack_take &&
            seq_reg == RVM_SEQ_IDLE;
         irq_num <= best_num;
         irq_level <= best_lvl;
      end
   end

   // Sequencer: one answer cycle after each taken request
   always_comb begin
      seq_next = seq_reg;
      case (seq_reg)
         RVM_SEQ_IDLE: begin
            if (ack_take || trap_take) begin
               seq_next = RVM_SEQ_ISSUE;
            end
         end
         RVM_SEQ_ISSUE: seq_next = RVM_SEQ_IDLE;
         default: seq_next = RVM_SEQ_IDLE;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         seq_reg <= RVM_SEQ_IDLE;
      end else if (ce) begin
         seq_reg <= seq_next;
      end
   end

   // Vector answer; a trap may name any of the 64 slots, break is 0
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         vec_valid <= 1'b0;
         vec_addr <= 32'h0000_0000;
         vec_num <= 6'h00;
         fetch_reg <= 32'h0000_0000;
      end else if (ce) begin
         vec_valid <= ack_take || trap_take;
         if (ack_take) begin
            vec_addr <= rvm_slot(vector_base_reg, irq_num);
            vec_num <= irq_num;
            fetch_reg <= rvm_slot(vector_base_reg, irq_num);
         end else if (trap_take) begin
            vec_addr <= rvm_slot(vector_base_reg, trap_num);
            vec_num <= trap_num;
            fetch_reg <= rvm_slot(vector_base_reg, trap_num);
         end
      end
   end

   // Read decode
   always_comb begin
      rd_data = 32'h0000_0000;
      rd_hit = 1'b1;
      case (rvm_word(s_axi_araddr))
         `RVM_OFS_BASE: rd_data = vector_base_reg;
         `RVM_OFS_SEL: rd_data = source_select_reg;
         `RVM_OFS_PEND_LO: rd_data = pend_reg[31:0];
         `RVM_OFS_PEND_HI: rd_data = pend_reg[63:32];
         `RVM_OFS_STATUS: begin
            rd_data[`RVM_ST_NUM_LSB +: 6] = irq_num;
            rd_data[`RVM_ST_LVL_LSB +: 3] = irq_level;
            rd_data[`RVM_ST_REQ_BIT] = irq_req;
            rd_data[`RVM_ST_VNUM_LSB +: 6] = vec_num;
         end
         `RVM_OFS_FETCH: rd_data = fetch_reg;
         default: begin
            rd_hit = 1'b0;
            for (int k = 0; k < `RVM_PRIO_WORDS; k++) begin
               if (rvm_word(s_axi_araddr) ==
                  `RVM_OFS_PRIO0 + 8'(4*k)) begin
                  rd_hit = 1'b1;
                  for (int j = 0; j < 8; j++) begin
                     rd_data[4*j +: 3] = prio_reg[8*k+j];
                  end
               end
            end
         end
      endcase
   end

   // Read channel: data is sampled as the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `RVM_RESP_OKAY;
      end else if (ce) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_data;
            s_axi_rresp <= rd_hit ? `RVM_RESP_OKAY : `RVM_RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

endmodule // rvm_vector_map
`default_nettype wire

/* verification/rvm_chk.sv */
// Checker for the vector map's CPU-side answers
`default_nettype none
module rvm_chk (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // CPU flags and requests
   input wire logic cpu_int_enable,
   input wire logic [2:0] processor_priority_level,
   input wire logic ack_req,
   input wire logic trap_req,
   input wire logic [5:0] trap_num,
   // Offer and answer
   input wire logic irq_req,
   input wire logic [5:0] irq_num,
   input wire logic [2:0] irq_level,
   input wire logic vec_valid,
   input wire logic [31:0] vec_addr,
   input wire logic [5:0] vec_num
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // An acknowledge the sequencer takes
   sequence s_ack;
      ack_req && irq_req && !vec_valid;
   endsequence
   // A trap taken; it loses to an acknowledge in the same cycle
   sequence s_trap;
      trap_req && !vec_valid && !(ack_req && irq_req);
   endsequence
   AST_ACK_NUM: assert property (
      s_ack |=> vec_valid && vec_num == $past(irq_num)) else $error("ack num");
   AST_ACK_DROP: assert property (
      s_ack |=> !irq_req) else $error("offer kept after ack");
   AST_TRAP: assert property (
      s_trap |=> vec_valid && vec_num == $past(trap_num)) else $error("trap");
   AST_LVL: assert property (
      irq_req |-> $past(cpu_int_enable)
         && irq_level > $past(processor_priority_level))
      else $error("offer masked");
   AST_RSV: assert property (
      irq_req |-> irq_num >= 6'h08 && irq_num <= 6'h39
         && !(irq_num inside {6'h32, 6'h33, 6'h37, 6'h38}))
      else $error("reserved number");
   AST_PULSE: assert property (
      vec_valid |=> !vec_valid) else $error("answer too long");
   AST_CAUSE: assert property (
      $rose(vec_valid) |-> $past(ack_req) || $past(trap_req))
      else $error("answer without cause");
   AST_HOLD: assert property (
      !vec_valid |-> $stable(vec_addr) && $stable(vec_num))
      else $error("answer not held");
endmodule // rvm_chk
bind rvm_vector_map rvm_chk chk (
   .aclk, .aresetn, .cpu_int_enable, .processor_priority_level, .ack_req,
   .trap_req, .trap_num, .irq_req, .irq_num, .irq_level, .vec_valid,
   .vec_addr, .vec_num
);
`default_nettype wire

/* verification/rvm_cpu_model.sv */
// Interrupt sequencer model that acknowledges offered requests
`default_nettype none
module rvm_cpu_model (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Answer delay in cycles, 0 is prompt
   input wire logic [3:0] dly,
   // Offer and answer
   input wire logic irq_req,
   input wire logic vec_valid,
   output logic ack_req
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] cnt;
   // Holds the acknowledge until the answer shows, as a real core would
   always_ff @(posedge aclk) begin
      if (!aresetn || vec_valid) begin
         ack_req <= 1'h0;
         cnt <= 4'h0;
      end else if (irq_req && !ack_req) begin
         if (cnt >= dly) ack_req <= 1'h1;
         cnt <= cnt + 4'h1;
      end
   end
endmodule // rvm_cpu_model
`default_nettype wire

/* verification/tb_top.sv */
// Self-checking bench for the relocatable vector map
`default_nettype none
`include "rvm_params.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready, cpu_int_enable;
   logic ack_req, trap_req, irq_req, vec_valid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [2:0] processor_priority_level, irq_level;
   logic [5:0] trap_num, irq_num, vec_num, ext;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, vec_addr, rd_v, base;
   logic [45:0] src;
   logic [3:0] dly;
   logic [5:0] tn [5] = '{6'h00, 6'h01, 6'h07, 6'h32, 6'h3F};
   int fails = 0, samples_checked = 0, cyc = 0, i;
   rvm_vector_map dut (
      .aclk, .aresetn, .ce(1'h1), .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu_int_enable,
      .processor_priority_level, .ack_req, .trap_req, .trap_num, .irq_req,
      .irq_num, .irq_level, .vec_valid, .vec_addr, .vec_num,
      .dma_done(src[3:0]), .timer_group_a_ch(src[8:4]),
      .uart_tx(src[13:9]), .uart_rx(src[18:14]),
      .timer_group_b_ch(src[24:19]), .uart_bus_cond(src[29:25]),
      .adc_unit0(src[30]), .key_input(src[31]), .aio_irq_lo(src[36:32]),
      .aio_irq_hi(src[39:37]), .can_irq(src[45:40]), .ext_pin_irq(ext));
   rvm_cpu_model cpu (.aclk, .aresetn, .dly, .irq_req, .vec_valid, .ack_req);
   // Clock
   initial begin
      aclk = 1'h0;
      forever #5 aclk = ~aclk;
   end
   task automatic chk(string n, logic [31:0] s, logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         fails++;
         $display("unexpected %s exp %h seen %h", n, e, s);
      end
   endtask
   task automatic final_report;
      if (fails == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Bus cycles hold every channel until its own handshake
   task automatic wr(logic [7:0] a, logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
         rsp = s_axi_bresp;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'h0;
      @(posedge aclk);
   endtask
   task automatic rd(logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
         rd_v = s_axi_rdata;
         rsp = s_axi_rresp;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'h0;
      @(posedge aclk);
   endtask
   // Waits a bounded time for one answer and checks it
   task automatic serve(logic [5:0] n);
      repeat (40) if (!vec_valid) @(posedge aclk);
      chk("vec_valid", vec_valid, 32'h1);
      chk("vec_num", vec_num, n);
      chk("vec_addr", vec_addr, base + {n, 2'h0});
      @(posedge aclk);
   endtask
   task automatic hit(int k);
      src[k] <= 1'h1;
      @(posedge aclk);
      src[k] <= 1'h0;
   endtask
   // Expected number of request line k of src
   function automatic logic [5:0] num_of(int k);
      int u;
      u = k < 14 ? k - 9 : k - 14;
      if (k < 9) return 6'(k + 8);
      if (k < 19) return 6'((u < 2 ? 17 : 29) + 2 * u + (k > 13));
      if (k < 24) return 6'(k + 2);
      if (k == 24) return 6'h20;
      if (k < 37) return 6'(k + 12);
      if (k < 40) return 6'(k + 15);
      return 6'(k == 42 ? 57 : k == 45 ? 49 : k < 42 ? k + 13 : k + 1);
   endfunction
   // Stops a hung run
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         final_report;
      end
   end
   // Main sequence
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, trap_req} = 5'h0;
      {s_axi_arvalid, s_axi_rready, trap_num, ext, src, dly} = 64'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      processor_priority_level = 3'h0;
      cpu_int_enable = 1'h1;
      base = 32'h0001_2301;
      repeat (4) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      rd(`RVM_OFS_BASE);
      chk("base reset", rd_v, `RVM_BASE_RST);
      rd(8'h3C);
      chk("unmapped", rsp, `RVM_RESP_SLVERR);
      wr(`RVM_OFS_BASE, base);
      chk("bresp", rsp, `RVM_RESP_OKAY);
      foreach (tn[j]) begin
         trap_req <= 1'h1;
         trap_num <= tn[j];
         @(posedge aclk);
         trap_req <= 1'h0;
         serve(tn[j]);
      end
      // Last trap named slot 63, the top word of the table
      rd(`RVM_OFS_FETCH);
      chk("fetch", rd_v, base + 32'h0000_00FC);
      for (i = 0; i < 8; i++) wr(8'h10 + 8'(4 * i), 32'h1111_1111);
      for (i = 0; i < 46; i++) begin
         if (i == 25 || i == 26) continue;
         dly <= 4'(i % 4);
         hit(i);
         serve(num_of(i));
      end
      for (i = 0; i < 6; i++) begin
         ext[i] <= 1'h1;
         repeat (4) @(posedge aclk);
         ext[i] <= 1'h0;
         serve(6'(31 - i));
      end
      hit(25);
      repeat (10) @(posedge aclk);
      chk("irq_req", irq_req, 32'h0);
      wr(`RVM_OFS_SEL, 32'h0000_00C0);
      hit(25);
      serve(`RVM_NUM_BUS30);
      hit(26);
      serve(`RVM_NUM_BUS41);
      cpu_int_enable <= 1'h0;
      hit(0);
      repeat (8) @(posedge aclk);
      chk("irq_req", irq_req, 32'h0);
      // Masked request still pends on number 8 alone
      rd(`RVM_OFS_PEND_LO);
      chk("pend", rd_v, 32'h0000_0100);
      cpu_int_enable <= 1'h1;
      serve(`RVM_NUM_DMA0);
      processor_priority_level <= 3'h1;
      hit(1);
      repeat (8) @(posedge aclk);
      chk("irq_req", irq_req, 32'h0);
      processor_priority_level <= 3'h0;
      serve(`RVM_NUM_DMA0 + 6'h1);
      final_report;
   end
endmodule // tb_top
`default_nettype wire
